// ### pidr_regulator.sv
// Process regulator: selects target and feedback, runs a PID update per sample period.
// Assumes all inputs synchronous to clk_sys; source values are unsigned, 0.1 % units.
//
// Notes on behaviour
// - Output adjusts frequency so feedback is driven toward target, negative feedback.
// - Proportional contribution scales with the present deviation.
// - Integral accumulates every sample while any deviation exists, saturating at the signed 32-bit limits.
// - Differential contribution follows only the change of deviation.
// - Enable bit: 0 disables the regulator, 1 enables; factory value 0.
// - Target selector: 0 digital,1/2 analog,4 pulse,5 comm,6 multistage,7 keypad.
// - Feedback selector: 0/1 analog, 3 pulse, 4 comm; 2 reserved.
// - Digital setpoint limited to 100.0 %, or to sensor range in water mode.
// - Second set gain 0..1000 and integral time 1..10000 ms.
// - Second set differential time 0..10000 ms.
// - Set switching: never, by terminal, by deviation, by regulator output.
// - One evaluation per sampling period of 1..60000 ms.
`timescale 1ns/1ps
`include "pidr_defines.svh"

module pidr_regulator #(
    parameter int MS_CYCLES = `PIDR_MS_TICK_CYCLES
) (
    // Clock and reset
    input  wire logic                clk_sys,
    input  wire logic                nrst,
    // Configuration
    input  wire logic                regulatorEnable,
    input  wire pidr_pkg::pidr_tsrc_t targetSourceSel,
    input  wire pidr_pkg::pidr_fsrc_t feedbackSourceSel,
    input  wire pidr_pkg::pidr_gsw_t gainSwitchSel,
    input  wire logic [15:0]         gainSwitchThreshold,
    input  wire logic [15:0]         samplingPeriod,
    input  wire logic                waterSupplyMode,
    input  wire logic [15:0]         maxSensorRange,
    input  wire logic [15:0]         digitalSetpoint,
    // Gain sets
    input  wire logic [9:0]          primaryPropGain,
    input  wire logic [13:0]         primaryIntegralTime,
    input  wire logic [13:0]         primaryDifferentialTime,
    input  wire logic [9:0]          secondaryPropGain,
    input  wire logic [13:0]         secondaryIntegralTime,
    input  wire logic [13:0]         secondaryDifferentialTime,
    input  wire logic                digitalInputTerminal,
    // Sources
    input  wire logic [15:0]         analogInputFirst,
    input  wire logic [15:0]         analogInputSecond,
    input  wire logic [15:0]         pulseInput,
    input  wire logic [15:0]         commInput,
    input  wire logic [15:0]         multistageInput,
    input  wire logic [15:0]         keypadInput,
    // Results
    output logic signed [31:0]       freqAdjust,
    output logic                     outValid,
    output logic                     secondaryActive,
    output logic                     selectError
);

    // ----------------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------------
    function automatic logic signed [31:0] sat32(input logic signed [47:0] v);
        if (v > 48'sh00007fffffff)
            return 32'sh7fffffff;
        else if (v < -48'sh000080000000)
            return -32'sh80000000;
        else
            return v[31:0];
    endfunction

    function automatic logic [31:0] abs32(input logic signed [31:0] v);
        return (v < 0) ? 32'(-v) : 32'(v);
    endfunction

    // ----------------------------------------------------------------------
    // Reset release
    // ----------------------------------------------------------------------
    logic rstMeta_n;
    logic rstSync_n;

    // Two stages so release never lands mid-cycle on the datapath
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            rstMeta_n <= 1'b0;
            rstSync_n <= 1'b0;
        end
        else
        begin
            rstMeta_n <= 1'b1;
            rstSync_n <= rstMeta_n;
        end
    end

    // ----------------------------------------------------------------------
    // Source selection
    // ----------------------------------------------------------------------
    logic [15:0] setpointLimit;
    logic [15:0] setpointClamped;
    logic [15:0] targetVal;
    logic [15:0] feedbackVal;
    logic        targetRsvd;
    logic        feedbackRsvd;

    // Setpoint clamp depends on the industry mode
    assign setpointLimit   = waterSupplyMode ? maxSensorRange : `PIDR_PCT_MAX;
    assign setpointClamped = (digitalSetpoint > setpointLimit) ? setpointLimit : digitalSetpoint;

    // Reserved codes select zero and raise selectError
    assign targetVal = (targetSourceSel == pidr_pkg::TSRC_DIGITAL)  ? setpointClamped :
                       (targetSourceSel == pidr_pkg::TSRC_AI_FIRST) ? analogInputFirst :
                       (targetSourceSel == pidr_pkg::TSRC_AI_SECND) ? analogInputSecond :
                       (targetSourceSel == pidr_pkg::TSRC_PULSE)    ? pulseInput :
                       (targetSourceSel == pidr_pkg::TSRC_COMM)     ? commInput :
                       (targetSourceSel == pidr_pkg::TSRC_MULTI)    ? multistageInput :
                       (targetSourceSel == pidr_pkg::TSRC_KEYPAD)   ? keypadInput : 16'h0;
    assign targetRsvd = (targetSourceSel == pidr_pkg::TSRC_RSVD3) || (targetSourceSel > pidr_pkg::TSRC_KEYPAD);

    // Feedback mux
    assign feedbackVal = (feedbackSourceSel == pidr_pkg::FSRC_AI_FIRST) ? analogInputFirst :
                         (feedbackSourceSel == pidr_pkg::FSRC_AI_SECND) ? analogInputSecond :
                         (feedbackSourceSel == pidr_pkg::FSRC_PULSE)    ? pulseInput :
                         (feedbackSourceSel == pidr_pkg::FSRC_COMM)     ? commInput : 16'h0;
    assign feedbackRsvd = (feedbackSourceSel == pidr_pkg::FSRC_RSVD2) || (feedbackSourceSel > pidr_pkg::FSRC_COMM);

    // ----------------------------------------------------------------------
    // Sequencer and datapath
    // ----------------------------------------------------------------------
    pidr_pkg::pidr_state_t state;
    pidr_pkg::pidr_state_t next_state;
    logic                  samplePulse;
    logic signed [16:0]    errNow;
    logic signed [16:0]    errPrev;
    logic signed [31:0]    integ;
    logic signed [31:0]    next_integ;
    logic signed [17:0]    errDelta;
    logic                  next_secondary;
    logic [9:0]            actKp;
    logic [13:0]           actTi;
    logic [13:0]           actTd;
    logic signed [47:0]    iTerm;
    logic signed [47:0]    dTerm;
    logic signed [47:0]    pidSum;
    logic signed [31:0]    next_out;
    logic                  capture;

    pidr_sample_timer #(
        .MS_CYCLES (MS_CYCLES)
    ) u_timer (
        .clk_sys     (clk_sys),
        .rstSync_n   (rstSync_n),
        .run         (regulatorEnable),
        .periodMs    (samplingPeriod),
        .samplePulse (samplePulse)
    );

    // One update per sample tick enable gates everything
    assign capture    = (state == pidr_pkg::ST_WAIT) && samplePulse;
    assign next_state = !regulatorEnable                  ? pidr_pkg::ST_DISABLED :
                        (state == pidr_pkg::ST_DISABLED)  ? pidr_pkg::ST_WAIT :
                        capture                           ? pidr_pkg::ST_UPDATE :
                        (state == pidr_pkg::ST_UPDATE)    ? pidr_pkg::ST_WAIT : state;

    // Set selection comparisons use the last settled values
    assign next_secondary = (gainSwitchSel == pidr_pkg::GSW_TERMINAL)  ? digitalInputTerminal :
                            (gainSwitchSel == pidr_pkg::GSW_DEVIATION) ? (abs32(32'(errNow)) > 32'(gainSwitchThreshold)) :
                            (gainSwitchSel == pidr_pkg::GSW_OUTPUT)    ? (abs32(freqAdjust) > 32'(gainSwitchThreshold)) :
                            1'b0;
    assign actKp = secondaryActive ? secondaryPropGain : primaryPropGain;
    assign actTi = secondaryActive ? secondaryIntegralTime : primaryIntegralTime;
    assign actTd = secondaryActive ? secondaryDifferentialTime : primaryDifferentialTime;

    // Accumulation continues while deviation is nonzero until it saturates at the signed 32-bit limits
    assign next_integ = sat32(48'(integ) + 48'(errNow));
    // Change of deviation only, sign of deviation irrelevant
    assign errDelta   = 18'(errNow) - 18'(errPrev);
    // Zero integral time is held at the minimum so the division stays defined
    assign iTerm      = 48'(next_integ) / 48'(signed'({1'b0, (actTi < `PIDR_TI_MIN) ? `PIDR_TI_MIN : actTi}));
    assign dTerm      = 48'(signed'({1'b0, actTd})) * 48'(errDelta);
    // Gain times the three summed terms proportional part is errNow
    assign pidSum     = 48'(errNow) + iTerm + dTerm;
    assign next_out   = sat32(pidSum * 48'(signed'({1'b0, actKp})));

    always_ff @(posedge clk_sys or negedge rstSync_n)
    begin
        if (!rstSync_n)
            state <= pidr_pkg::ST_DISABLED;
        else
            state <= next_state;
    end

    // Deviation capture: target minus feedback keeps the loop negative
    always_ff @(posedge clk_sys or negedge rstSync_n)
    begin
        if (!rstSync_n)
        begin
            errNow  <= 17'sh0;
            errPrev <= 17'sh0;
        end
        else if (!regulatorEnable)
        begin
            errNow  <= 17'sh0;
            errPrev <= 17'sh0;
        end
        else if (capture)
        begin
            errNow  <= 17'(signed'({1'b0, targetVal})) - 17'(signed'({1'b0, feedbackVal}));
            errPrev <= errNow;
        end
    end

    // Result registers; disabling clears the integral and the output
    always_ff @(posedge clk_sys or negedge rstSync_n)
    begin
        if (!rstSync_n)
        begin
            integ           <= 32'sh0;
            freqAdjust      <= 32'sh0;
            outValid        <= 1'b0;
            secondaryActive <= 1'b0;
            selectError     <= 1'b0;
        end
        else
        begin
            outValid    <= 1'b0;
            selectError <= targetRsvd || feedbackRsvd;
            if (!regulatorEnable)
            begin
                integ           <= 32'sh0;
                freqAdjust      <= 32'sh0;
                secondaryActive <= 1'b0;
            end
            else
            begin
                secondaryActive <= next_secondary;
                if (state == pidr_pkg::ST_UPDATE)
                begin
                    integ      <= next_integ;
                    freqAdjust <= next_out;
                    outValid   <= 1'b1;
                end
            end
        end
    end

    // ----------------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstSync_n);

    a_disable_clears: assert property (!regulatorEnable |=> (integ == 0) && (freqAdjust == 0) && !outValid)
        else $error("disabled regulator kept state");
    a_target_ai_first: assert property (capture && regulatorEnable && targetSourceSel == pidr_pkg::TSRC_AI_FIRST
        && feedbackSourceSel == pidr_pkg::FSRC_AI_SECND |=>
        errNow == 17'(signed'({1'b0, $past(analogInputFirst)})) - 17'(signed'({1'b0, $past(analogInputSecond)})))
        else $error("target analog decode wrong");
    a_feedback_pulse: assert property (capture && regulatorEnable && targetSourceSel == pidr_pkg::TSRC_COMM
        && feedbackSourceSel == pidr_pkg::FSRC_PULSE |=>
        errNow == 17'(signed'({1'b0, $past(commInput)})) - 17'(signed'({1'b0, $past(pulseInput)})))
        else $error("feedback pulse decode wrong");
    a_integ_accum: assert property (state == pidr_pkg::ST_UPDATE && regulatorEnable && integ > -32'sh40000000
        && integ < 32'sh40000000 |=> integ == $past(integ) + 32'($past(errNow)))
        else $error("integral did not accumulate deviation");
    a_valid_single: assert property (outValid |=> !outValid)
        else $error("result strobe longer than one cycle");
    a_sample_to_out: assert property (capture && regulatorEnable |=> regulatorEnable |-> ##1 outValid)
        else $error("sample tick did not yield a result");
    a_set_never: assert property (gainSwitchSel == pidr_pkg::GSW_NEVER |=> !secondaryActive)
        else $error("set switched while switching disabled");
    a_set_terminal: assert property (regulatorEnable && gainSwitchSel == pidr_pkg::GSW_TERMINAL
        |=> secondaryActive == $past(digitalInputTerminal))
        else $error("terminal set switching wrong");

    c_update_seen: cover property (capture ##1 state == pidr_pkg::ST_UPDATE ##1 outValid);
    c_secondary_used: cover property (outValid && secondaryActive);
    c_reserved_sel: cover property (selectError);

endmodule // pidr_regulator

// ### pidr_defines.svh
// Constants of the process regulator: factory values, limits, timing.
// Assumes 100 MHz system clock; percentages are in 0.1 % units.
`ifndef PIDR_DEFINES_SVH
`define PIDR_DEFINES_SVH

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define PIDR_CLK_PERIOD_NS   10
`define PIDR_MS_TICK_NS      1000000
`define PIDR_MS_TICK_CYCLES  ((`PIDR_MS_TICK_NS + `PIDR_CLK_PERIOD_NS - 1) / `PIDR_CLK_PERIOD_NS)
`define PIDR_SAMPLE_MIN_MS   16'h0001
`define PIDR_SAMPLE_MAX_MS   16'hea60

// ----------------------------------------------------------------------
// Factory values and ranges
// ----------------------------------------------------------------------
`define PIDR_ENABLE_RST      1'b0
`define PIDR_PCT_MAX         16'h03e8
`define PIDR_KP1_RST         10'h00a
`define PIDR_TI1_RST         14'h01f4
`define PIDR_TD1_RST         14'h0000
`define PIDR_KP2_RST         10'h005
`define PIDR_TI2_RST         14'h07d0
`define PIDR_TD2_RST         14'h0000
`define PIDR_TI_MIN          14'h0001
`define PIDR_SENSOR_RANGE_RST 16'h0064

`endif

// ### pidr_pkg.sv
// Types of the process regulator: state machine and selector enumerations.
// Assumes pidr_defines.svh is used alongside for numeric constants.
package pidr_pkg;

    // ----------------------------------------------------------------------
    // Sequencer states, Gray coded along disabled-wait-update
    // ----------------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_DISABLED = 2'h0,
        ST_WAIT     = 2'h1,
        ST_UPDATE   = 2'h3
    } pidr_state_t;

    // ----------------------------------------------------------------------
    // Selector encodings
    // ----------------------------------------------------------------------
    typedef enum logic [3:0] {
        TSRC_DIGITAL  = 4'h0,
        TSRC_AI_FIRST = 4'h1,
        TSRC_AI_SECND = 4'h2,
        TSRC_RSVD3    = 4'h3,
        TSRC_PULSE    = 4'h4,
        TSRC_COMM     = 4'h5,
        TSRC_MULTI    = 4'h6,
        TSRC_KEYPAD   = 4'h7,
        TSRC_RSVD8    = 4'h8
    } pidr_tsrc_t;

    typedef enum logic [2:0] {
        FSRC_AI_FIRST = 3'h0,
        FSRC_AI_SECND = 3'h1,
        FSRC_RSVD2    = 3'h2,
        FSRC_PULSE    = 3'h3,
        FSRC_COMM     = 3'h4
    } pidr_fsrc_t;

    typedef enum logic [1:0] {
        GSW_NEVER     = 2'h0,
        GSW_TERMINAL  = 2'h1,
        GSW_DEVIATION = 2'h2,
        GSW_OUTPUT    = 2'h3
    } pidr_gsw_t;

endpackage

// ### pidr_sample_timer.sv
// Sampling period timer: a 1 ms enable divider followed by a period counter.
// Assumes a synchronous, already released reset and a 100 MHz clock.
`timescale 1ns/1ps
`include "pidr_defines.svh"

module pidr_sample_timer #(
    parameter int MS_CYCLES = `PIDR_MS_TICK_CYCLES
) (
    // Clock and reset
    input  wire logic        clk_sys,
    input  wire logic        rstSync_n,
    // Control
    input  wire logic        run,
    input  wire logic [15:0] periodMs,
    // Event
    output logic             samplePulse
);

    // ----------------------------------------------------------------------
    // Counters
    // ----------------------------------------------------------------------
    logic [31:0] cycleCount;
    logic [15:0] msCount;
    logic [15:0] periodLim;
    logic        msTick;

    // Out-of-range settings are clamped so a zero period cannot stall sampling
    assign periodLim = (periodMs < `PIDR_SAMPLE_MIN_MS) ? `PIDR_SAMPLE_MIN_MS :
                       (periodMs > `PIDR_SAMPLE_MAX_MS) ? `PIDR_SAMPLE_MAX_MS : periodMs;
    assign msTick    = (cycleCount == 32'(MS_CYCLES - 1));

    // Millisecond divider and period counter; both restart while stopped
    always_ff @(posedge clk_sys or negedge rstSync_n)
    begin
        if (!rstSync_n)
        begin
            cycleCount  <= 32'h0;
            msCount     <= 16'h0;
            samplePulse <= 1'b0;
        end
        else
        begin
            samplePulse <= 1'b0;
            if (!run)
            begin
                cycleCount <= 32'h0;
                msCount    <= 16'h0;
            end
            else if (msTick)
            begin
                cycleCount <= 32'h0;
                if (msCount >= periodLim - 16'h1)
                begin
                    msCount     <= 16'h0;
                    samplePulse <= 1'b1;
                end
                else
                    msCount <= msCount + 16'h1;
            end
            else
                cycleCount <= cycleCount + 32'h1;
        end
    end

endmodule // pidr_sample_timer

// ### pidr_source_model.sv
// Model of the setpoint and feedback sources that feed the process regulator.
// Assumes the bench sets each level just after a clock edge; levels are 0.1 % units.
`timescale 1ns/1ps

module pidr_source_model (
    // Source levels
    output logic [15:0] analogInputFirst,
    output logic [15:0] analogInputSecond,
    output logic [15:0] pulseInput,
    output logic [15:0] commInput,
    output logic [15:0] multistageInput,
    output logic [15:0] keypadInput
);
    logic [15:0] level [6];

    // Levels hold until changed, as a settled sensor or keypad value would
    initial
    begin
        for (int i = 0; i < 6; i++) level[i] = 16'h0000;
    end

    task automatic setLevel(input int ch, input logic [15:0] v);
        level[ch] = v;
    endtask

    // Channel order: analog first, analog second, pulse, comm, multistage, keypad
    assign analogInputFirst  = level[0];
    assign analogInputSecond = level[1];
    assign pulseInput        = level[2];
    assign commInput         = level[3];
    assign multistageInput   = level[4];
    assign keypadInput       = level[5];
endmodule // pidr_source_model

// ### pidr_regulator_test.sv
// Self-checking bench of the process regulator; expected results queue up for the watcher.
// Assumes MS_CYCLES shortened to 4 so one millisecond is four clock cycles.
`timescale 1ns/1ps
`define TB_CHK(what, ex, got) begin total_checks++; if ((got) !== (ex)) begin err_total++; \
    $display("wrong value %s expected %0h seen %0h", what, ex, got); end end

module pidr_regulator_test;
    localparam int MS = 4;
    localparam int PER_MS = 2;
    logic clk_sys, nrst, regulatorEnable, waterSupplyMode, digitalInputTerminal, outValid;
    logic secondaryActive, selectError;
    pidr_pkg::pidr_tsrc_t targetSourceSel;
    pidr_pkg::pidr_fsrc_t feedbackSourceSel;
    pidr_pkg::pidr_gsw_t gainSwitchSel;
    logic [15:0] gainSwitchThreshold, samplingPeriod, maxSensorRange, digitalSetpoint;
    logic [15:0] ai1, ai2, pls, com, mst, kpd;
    logic [9:0]  primaryPropGain, secondaryPropGain;
    logic [13:0] primaryIntegralTime, primaryDifferentialTime, secondaryIntegralTime, secondaryDifferentialTime;
    logic signed [31:0] freqAdjust, expV;
    logic signed [31:0] expQ [$];
    int err_total, total_checks, seed, cyc, lastValid, lv [6], tgt, fbk;

    // ------------------------------------------------------------------
    // Clock, design and source model
    // ------------------------------------------------------------------
    initial
    begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    pidr_source_model src (.analogInputFirst(ai1), .analogInputSecond(ai2), .pulseInput(pls),
        .commInput(com), .multistageInput(mst), .keypadInput(kpd));

    pidr_regulator #(.MS_CYCLES(MS)) uut (.clk_sys(clk_sys), .nrst(nrst),
        .regulatorEnable(regulatorEnable), .targetSourceSel(targetSourceSel),
        .feedbackSourceSel(feedbackSourceSel), .gainSwitchSel(gainSwitchSel),
        .gainSwitchThreshold(gainSwitchThreshold), .samplingPeriod(samplingPeriod),
        .waterSupplyMode(waterSupplyMode), .maxSensorRange(maxSensorRange),
        .digitalSetpoint(digitalSetpoint), .primaryPropGain(primaryPropGain),
        .primaryIntegralTime(primaryIntegralTime), .primaryDifferentialTime(primaryDifferentialTime),
        .secondaryPropGain(secondaryPropGain), .secondaryIntegralTime(secondaryIntegralTime),
        .secondaryDifferentialTime(secondaryDifferentialTime), .digitalInputTerminal(digitalInputTerminal),
        .analogInputFirst(ai1), .analogInputSecond(ai2), .pulseInput(pls), .commInput(com),
        .multistageInput(mst), .keypadInput(kpd), .freqAdjust(freqAdjust), .outValid(outValid),
        .secondaryActive(secondaryActive), .selectError(selectError));

    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    task automatic final_report();
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // Random levels kept inside 0..100.0 % so every source value is legal
    task automatic randLevels();
        for (int i = 0; i < 6; i++)
        begin
            lv[i] = $unsigned($random(seed)) % 1001;
            src.setLevel(i, 16'(lv[i]));
        end
        digitalSetpoint = 16'($unsigned($random(seed)) % 1001);
    endtask

    // Queue n expected results, enable, wait for them, check flags, disable
    task automatic runSamples(input int n, input int e, input int kp, input int ti, input int td,
                              input logic sel, input logic sec);
        for (int k = 1; k <= n; k++) expQ.push_back(32'(kp * (e + (k * e) / ti + (k == 1 ? td * e : 0))));
        regulatorEnable = 1'b1;
        for (int i = 0; i < 40 * n && expQ.size() > 0; i++) @(posedge clk_sys);
        if (expQ.size() != 0)
        begin
            err_total++;
            $display("wrong value pending results expected 0 seen %0d", expQ.size());
            expQ.delete();
        end
        #1;
        `TB_CHK("selectError", sel, selectError);
        `TB_CHK("secondaryActive", sec, secondaryActive);
        regulatorEnable = 1'b0;
        repeat (3) @(posedge clk_sys);
        #1;
        `TB_CHK("freqAdjust when disabled", 32'sh0, freqAdjust);
    endtask

    // ------------------------------------------------------------------
    // Watcher: every result pops the oldest expectation
    // ------------------------------------------------------------------
    always @(posedge clk_sys)
    begin
        #2;
        cyc++;
        if (outValid === 1'b1)
        begin
            if (expQ.size() == 0)
            begin
                err_total++;
                $display("wrong value outValid expected 0 seen 1");
            end
            else
            begin
                expV = expQ.pop_front();
                `TB_CHK("freqAdjust", expV, freqAdjust);
            end
            if (lastValid >= 0) `TB_CHK("sample spacing", PER_MS * MS, cyc - lastValid);
            lastValid = cyc;
        end
        if (regulatorEnable !== 1'b1) lastValid = -1;
    end

    // Watchdog: the whole run needs well under 40000 cycles
    initial
    begin
        #400000;
        err_total++;
        $display("wrong value run time expected done seen hang");
        final_report();
    end

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial
    begin
        seed = 3228;
        {nrst, regulatorEnable, waterSupplyMode, digitalInputTerminal} = 4'h0;
        targetSourceSel = pidr_pkg::TSRC_DIGITAL;
        feedbackSourceSel = pidr_pkg::FSRC_AI_FIRST;
        gainSwitchSel = pidr_pkg::GSW_NEVER;
        {gainSwitchThreshold, maxSensorRange, digitalSetpoint} = {16'hffff, 16'h0064, 16'h0000};
        samplingPeriod = 16'(PER_MS);
        {primaryPropGain, secondaryPropGain} = {10'h001, 10'h001};
        {primaryIntegralTime, secondaryIntegralTime} = {14'h0001, 14'h0001};
        {primaryDifferentialTime, secondaryDifferentialTime} = 28'h0;
        repeat (16) @(posedge clk_sys);
        #1 nrst = 1'b1;
        repeat (40) @(posedge clk_sys);
        #1;
        `TB_CHK("outValid while disabled", 1'b0, outValid);
        `TB_CHK("freqAdjust after reset", 32'sh0, freqAdjust);
        $display("test reset done");
        // Every target code, reserved ones read as zero with the error flag
        // Feedback from the second analog input, so target code 2 compares that channel with itself
        feedbackSourceSel = pidr_pkg::FSRC_AI_SECND;
        for (int t = 0; t < 9; t++)
        begin
            randLevels();
            targetSourceSel = pidr_pkg::pidr_tsrc_t'(4'(t));
            tgt = (t == 0) ? int'(digitalSetpoint) : (t == 1) ? lv[0] : (t == 2) ? lv[1] : (t == 4) ? lv[2] :
                  (t == 5) ? lv[3] : (t == 6) ? lv[4] : (t == 7) ? lv[5] : 0;
            runSamples(2, tgt - lv[1], 1, 1, 0, (t == 3 || t == 8), 1'b0);
        end
        $display("test target sources done");
        // Target from communication so each feedback channel meets a known random target
        targetSourceSel = pidr_pkg::TSRC_COMM;
        for (int f = 0; f < 5; f++)
        begin
            randLevels();
            feedbackSourceSel = pidr_pkg::pidr_fsrc_t'(3'(f));
            fbk = (f == 0) ? lv[0] : (f == 1) ? lv[1] : (f == 3) ? lv[2] : (f == 4) ? lv[3] : 0;
            runSamples(2, lv[3] - fbk, 1, 1, 0, (f == 2), 1'b0);
        end
        $display("test feedback sources done");
        // Integral grows each sample; differential kicks once from a cleared history
        targetSourceSel = pidr_pkg::TSRC_DIGITAL;
        feedbackSourceSel = pidr_pkg::FSRC_AI_FIRST;
        src.setLevel(0, 16'h0064);
        digitalSetpoint = 16'h0258;
        {primaryPropGain, primaryIntegralTime} = {10'h002, 14'h0003};
        runSamples(4, 500, 2, 3, 0, 1'b0, 1'b0);
        {primaryPropGain, primaryIntegralTime, primaryDifferentialTime} = {10'h001, 14'h03e8, 14'h0005};
        runSamples(3, 500, 1, 1000, 5, 1'b0, 1'b0);
        primaryDifferentialTime = 14'h0000;
        $display("test integral and differential done");
        // Setpoint clamps: 100.0 % in general mode, sensor range in water mode
        src.setLevel(0, 16'h0000);
        digitalSetpoint = 16'h07d0;
        runSamples(1, 1000, 1, 1000, 0, 1'b0, 1'b0);
        waterSupplyMode = 1'b1;
        runSamples(1, 100, 1, 1000, 0, 1'b0, 1'b0);
        waterSupplyMode = 1'b0;
        $display("test setpoint limits done");
        // Gain set switching by terminal with distinct gains
        digitalSetpoint = 16'h00c8;
        {primaryPropGain, primaryIntegralTime, secondaryPropGain, secondaryIntegralTime} =
            {10'h007, 14'h2710, 10'h3e8, 14'h0001};
        digitalInputTerminal = 1'b1;
        runSamples(2, 200, 7, 10000, 0, 1'b0, 1'b0);
        gainSwitchSel = pidr_pkg::GSW_TERMINAL;
        runSamples(2, 200, 1000, 1, 0, 1'b0, 1'b1);
        digitalInputTerminal = 1'b0;
        runSamples(2, 200, 7, 10000, 0, 1'b0, 1'b0);
        // Automatic modes with equal sets, so only the flag tells them apart
        {secondaryPropGain, secondaryIntegralTime} = {10'h007, 14'h2710};
        gainSwitchSel = pidr_pkg::GSW_DEVIATION;
        gainSwitchThreshold = 16'h0000;
        runSamples(2, 200, 7, 10000, 0, 1'b0, 1'b1);
        gainSwitchThreshold = 16'h03e8;
        runSamples(2, 200, 7, 10000, 0, 1'b0, 1'b0);
        gainSwitchSel = pidr_pkg::GSW_OUTPUT;
        gainSwitchThreshold = 16'h0000;
        runSamples(2, 200, 7, 10000, 0, 1'b0, 1'b1);
        $display("test gain switching done");
        final_report();
    end
endmodule // pidr_regulator_test
